// ### design/alu_exec_defs.svh
`ifndef ALU_EXEC_DEFS_SVH
`define ALU_EXEC_DEFS_SVH

// bit positions inside the status flag byte
`define FLG_C 0
`define FLG_Z 1
`define FLG_N 2
`define FLG_V 3
`define FLG_S 4
`define FLG_H 5
`define FLG_T 6
`define FLG_I 7

// execution lengths in clock cycles
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_THREE 3'h3
`define CYC_CALL 3'h4
`define CYC_RET_SHORT 3'h4
`define CYC_RET_LONG 3'h5

// register port addresses
`define ADDR_FLAGS 3'h0
`define ADDR_EXT_HIGH 3'h1
`define ADDR_PC_LO 3'h2
`define ADDR_PC_MID 3'h3
`define ADDR_PC_HI 3'h4

// reset values
`define FLAGS_RST 8'h00
`define EXT_HIGH_RST 6'h00

`endif

// ### design/alu_exec_pkg.sv
package alu_exec_pkg;

  // operations handed over by the decode stage
  typedef enum logic [5:0] {
    OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CP, OP_CPC,
    OP_AND, OP_OR, OP_EOR, OP_SETMASK, OP_CLRMASK, OP_TEST,
    OP_WADD, OP_WSUB,
    OP_MUL, OP_MULS, OP_MULMX, OP_FMUL, OP_FMULS, OP_FMULMX,
    OP_JREL, OP_JIND, OP_JXIND, OP_CALLX, OP_RET, OP_IRET,
    OP_SKEQ, OP_SKIP_REG_CLR, OP_SKIP_REG_SET, OP_SKIP_IO_CLR, OP_SKIP_IO_SET,
    OP_BR_SET, OP_BR_CLR, OP_BR_GE, OP_BR_LT
  } op_t;

  // one decoded instruction with its operands
  typedef struct packed {
    op_t op;
    logic use_imm;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [7:0] imm;
    logic [15:0] pair_val;
    logic [15:0] z_ptr;
    logic [2:0] bit_sel;
    logic [7:0] io_val;
    logic [11:0] offset;
    logic next_two_word;
  } exec_req_t;

  // write-back toward the register file
  typedef struct packed {
    logic byte_en;
    logic word_en;
    logic prod_en;
    logic [15:0] data;
  } wb_t;

endpackage

// ### design/alu_byte_unit.sv
`timescale 1ns/10ps
`include "alu_exec_defs.svh"
module alu_byte_unit import alu_exec_pkg::*; (
  // operation and operands
  input wire op_t op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic [7:0] flags_in,
  // result
  output logic [7:0] res_out,
  output logic [7:0] flags_out,
  output logic wr_out
);
  logic [8:0] sum;
  logic ci;
  logic chain;

  // byte arithmetic and logic with flag generation
  always_comb begin
    sum = 9'h000;
    res_out = a_in;
    flags_out = flags_in;
    wr_out = 1'b0;
    ci = flags_in[`FLG_C] & (op_in == OP_ADC || op_in == OP_SBC || op_in == OP_CPC);
    chain = (op_in == OP_SBC || op_in == OP_CPC);
    unique case (op_in)
      OP_ADD, OP_ADC: begin
        sum = {1'b0, a_in} + {1'b0, b_in} + {8'h00, ci};
        res_out = sum[7:0];
        wr_out = 1'b1;
        flags_out[`FLG_C] = sum[8];
        flags_out[`FLG_H] = (a_in[3] & b_in[3]) | (b_in[3] & ~sum[3]) | (~sum[3] & a_in[3]);
        flags_out[`FLG_V] = (a_in[7] & b_in[7] & ~sum[7]) | (~a_in[7] & ~b_in[7] & sum[7]);
      end
      OP_SUB, OP_SBC, OP_CP, OP_CPC: begin
        sum = {1'b0, a_in} - {1'b0, b_in} - {8'h00, ci}; // RULE1
        res_out = sum[7:0];
        wr_out = (op_in == OP_SUB || op_in == OP_SBC); // RULE22
        flags_out[`FLG_C] = (~a_in[7] & b_in[7]) | (b_in[7] & sum[7]) | (sum[7] & ~a_in[7]);
        flags_out[`FLG_H] = (~a_in[3] & b_in[3]) | (b_in[3] & sum[3]) | (sum[3] & ~a_in[3]);
        flags_out[`FLG_V] = (a_in[7] & ~b_in[7] & ~sum[7]) | (~a_in[7] & b_in[7] & sum[7]);
      end
      OP_AND, OP_OR, OP_EOR, OP_SETMASK, OP_CLRMASK, OP_TEST: begin
        unique case (op_in)
          OP_AND: res_out = a_in & b_in; // RULE4
          OP_OR, OP_SETMASK: res_out = a_in | b_in; // RULE5
          OP_EOR: res_out = a_in ^ b_in;
          OP_CLRMASK: res_out = a_in & ~b_in; // RULE6
          default: res_out = a_in & a_in; // RULE7
        endcase
        wr_out = (op_in != OP_TEST);
        flags_out[`FLG_V] = 1'b0;
      end
      default: ;
    endcase
    // carry-chained subtracts keep zero only if it was already set
    flags_out[`FLG_Z] = (res_out == 8'h00) & (~chain | flags_in[`FLG_Z]); // RULE22
    flags_out[`FLG_N] = res_out[7];
    flags_out[`FLG_S] = res_out[7] ^ flags_out[`FLG_V];
  end
endmodule

// ### design/return_stack_mem.sv
`timescale 1ns/10ps
module return_stack_mem #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 16
) (
  // clock
  input wire logic clk_in,
  input wire logic ce_in,
  // write side
  input wire logic wr_en_in,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // read side, data one cycle after the enable
  input wire logic rd_en_in,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem [DEPTH];

  // storage write
  always_ff @(posedge clk_in) begin
    if (ce_in && wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // registered read, held until the next enable
  always_ff @(posedge clk_in) begin
    if (ce_in && rd_en_in) begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule

// ### design/alu_branch_exec.sv
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`include "alu_exec_defs.svh"
// Summary of operation
// RULE1 - immediate subtract with borrow in one cycle, all six arithmetic flags
// RULE2 - word add immediate in two cycles, half-carry untouched
// RULE3 - word subtract immediate in two cycles, half-carry untouched
// RULE4 - and, or, xor in one cycle, updating only zero, negative, overflow, sign
// RULE5 - set mask bits ors the mask in, one cycle, logic flags
// RULE6 - clear mask bits ands with the inverted mask, one cycle, logic flags
// RULE7 - zero-minus test ands register with itself, value unchanged, logic flags
// RULE8 - unsigned, signed and mixed multiply into product pair, two cycles, zero and carry
// RULE9 - fractional multiplies shift the product left one, two cycles
// RULE10 - indirect jump loads pointer into low bits, clears upper bits, two cycles
// RULE11 - extended indirect jump takes upper bits from the extended high register
// RULE12 - extended indirect call pushes return address, four cycles
// RULE13 - compare skip equal skips next instruction, one to three cycles
// RULE14 - skip on register bit cleared, or set for the companion
// RULE15 - skip on io bit set, or cleared for the companion
// RULE16 - flag branch goes to pc plus offset plus one, one or two cycles
// RULE17 - signed greater-or-equal taken when negative xor overflow is zero
// RULE18 - signed less-than taken when negative xor overflow is one
// RULE19 - unsigned same-or-higher taken on carry clear, lower on carry set
// RULE20 - interrupt enable branch taken on flag set, or clear for companion
// RULE21 - half-carry branch taken on set, or clear for companion
// RULE22 - register add, subtract, compare in one cycle; compares do not write
// RULE23 - relative jump two cycles; returns four or five; interrupt return sets enable
module alu_branch_exec import alu_exec_pkg::*; #(
  parameter int PC_W = 22,
  parameter int STACK_DEPTH = 16
) (
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  // instruction from decode
  input wire logic req_valid_in,
  input wire exec_req_t req_in,
  output logic busy_out,
  output logic done_out,
  // results
  output wb_t wb_out,
  output logic [7:0] flags_out,
  output logic [PC_W-1:0] pc_out,
  // register port
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out
);
  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam logic [2:0] RET_CYC = (PC_W > 16) ? `CYC_RET_LONG : `CYC_RET_SHORT;

  generate
    if (PC_W < 16 || PC_W > 22 || STACK_DEPTH < 2) begin : g_bad_param
      $error("alu_branch_exec: PC_W must be 16..22 and STACK_DEPTH at least 2");
    end
  endgenerate

  logic accept;
  logic commit;
  logic take;
  logic n_push;
  logic n_pop;
  logic busy_reg;
  logic done_reg;
  logic pend_pop_reg;
  logic alu_wr;
  logic mul_frac;
  logic [2:0] n_cyc;
  logic [2:0] count_reg;
  logic [7:0] opnd_b;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic [7:0] n_flags;
  logic [7:0] c_flags;
  logic [7:0] flags_reg;
  logic [7:0] pend_flags_reg;
  logic [7:0] rd_data_reg;
  logic [5:0] ext_high_reg;
  logic [8:0] mul_a;
  logic [8:0] mul_b;
  logic [17:0] prod_full;
  logic [15:0] prod_res;
  logic [15:0] word_res;
  logic [21:0] ext_target;
  logic [SP_W-1:0] sp_reg;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_plus1;
  logic [PC_W-1:0] n_pc;
  logic [PC_W-1:0] c_pc;
  logic [PC_W-1:0] pend_pc_reg;
  logic [PC_W-1:0] stack_rdata;
  wb_t n_wb;
  wb_t c_wb;
  wb_t wb_reg;
  wb_t pend_wb_reg;

  // selects one bit of a byte; used for register, io and flag tests
  function automatic logic bit_pick(input logic [7:0] v, input logic [2:0] s);
    return v[s];
  endfunction

  // relative target: pc plus one plus signed offset
  function automatic logic [PC_W-1:0] pc_rel(input logic [PC_W-1:0] pc,
                                              input logic [11:0] off);
    return pc + PC_W'(1) + {{(PC_W-12){off[11]}}, off};
  endfunction

  assign accept = ce_in & req_valid_in & ~busy_reg;
  assign opnd_b = req_in.use_imm ? req_in.imm : req_in.rr_val;
  assign pc_plus1 = pc_reg + PC_W'(1);
  assign ext_target = {ext_high_reg, req_in.z_ptr};

  alu_byte_unit u_alu (
    .op_in(req_in.op),
    .a_in(req_in.rd_val),
    .b_in(opnd_b),
    .flags_in(flags_reg),
    .res_out(alu_res),
    .flags_out(alu_flags),
    .wr_out(alu_wr)
  );

  // multiplier operands: sign-extend only the signed side
  always_comb begin
    mul_a = {1'b0, req_in.rd_val};
    mul_b = {1'b0, req_in.rr_val};
    if (req_in.op inside {OP_MULS, OP_MULMX, OP_FMULS, OP_FMULMX}) begin
      mul_a = {req_in.rd_val[7], req_in.rd_val}; // RULE8
    end
    if (req_in.op inside {OP_MULS, OP_FMULS}) begin
      mul_b = {req_in.rr_val[7], req_in.rr_val};
    end
    mul_frac = req_in.op inside {OP_FMUL, OP_FMULS, OP_FMULMX};
  end

  assign prod_full = $signed({{9{mul_a[8]}}, mul_a}) * $signed({{9{mul_b[8]}}, mul_b});
  assign prod_res = mul_frac ? {prod_full[14:0], 1'b0} : prod_full[15:0]; // RULE9

  // decode: result, flags, next pc and length of each instruction
  always_comb begin
    n_cyc = `CYC_ONE;
    n_wb = '0;
    n_flags = flags_reg;
    n_pc = pc_plus1;
    n_push = 1'b0;
    n_pop = 1'b0;
    take = 1'b0;
    word_res = 16'h0000;
    unique case (req_in.op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CP, OP_CPC,
      OP_AND, OP_OR, OP_EOR, OP_SETMASK, OP_CLRMASK, OP_TEST: begin
        n_wb.byte_en = alu_wr; // RULE22
        n_wb.data = {8'h00, alu_res};
        n_flags = alu_flags; // RULE1 RULE4 RULE5 RULE6 RULE7
      end
      OP_WADD, OP_WSUB: begin
        n_cyc = `CYC_TWO; // RULE2 RULE3
        n_wb.word_en = 1'b1;
        if (req_in.op == OP_WADD) begin
          word_res = req_in.pair_val + {10'h000, req_in.imm[5:0]}; // RULE2
          n_flags[`FLG_V] = ~req_in.pair_val[15] & word_res[15];
          n_flags[`FLG_C] = ~word_res[15] & req_in.pair_val[15];
        end else begin
          word_res = req_in.pair_val - {10'h000, req_in.imm[5:0]}; // RULE3
          n_flags[`FLG_V] = req_in.pair_val[15] & ~word_res[15];
          n_flags[`FLG_C] = word_res[15] & ~req_in.pair_val[15];
        end
        n_wb.data = word_res;
        n_flags[`FLG_Z] = (word_res == 16'h0000);
        n_flags[`FLG_N] = word_res[15];
        n_flags[`FLG_S] = word_res[15] ^ n_flags[`FLG_V];
      end
      OP_MUL, OP_MULS, OP_MULMX, OP_FMUL, OP_FMULS, OP_FMULMX: begin
        n_cyc = `CYC_TWO; // RULE8 RULE9
        n_wb.prod_en = 1'b1;
        n_wb.data = prod_res;
        n_flags[`FLG_C] = prod_full[15];
        n_flags[`FLG_Z] = (prod_res == 16'h0000);
      end
      OP_JREL: begin
        n_cyc = `CYC_TWO; // RULE23
        n_pc = pc_rel(pc_reg, req_in.offset);
      end
      OP_JIND: begin
        n_cyc = `CYC_TWO;
        n_pc = PC_W'(req_in.z_ptr); // RULE10
      end
      OP_JXIND: begin
        n_cyc = `CYC_TWO;
        n_pc = ext_target[PC_W-1:0]; // RULE11
      end
      OP_CALLX: begin
        n_cyc = `CYC_CALL; // RULE12
        n_push = 1'b1;
        n_pc = ext_target[PC_W-1:0];
      end
      OP_RET, OP_IRET: begin
        n_cyc = RET_CYC; // RULE23
        n_pop = 1'b1;
        if (req_in.op == OP_IRET) begin
          n_flags[`FLG_I] = 1'b1;
        end
      end
      OP_SKEQ, OP_SKIP_REG_CLR, OP_SKIP_REG_SET, OP_SKIP_IO_CLR, OP_SKIP_IO_SET: begin
        unique case (req_in.op)
          OP_SKEQ: take = (req_in.rd_val == req_in.rr_val); // RULE13
          OP_SKIP_REG_CLR: take = ~bit_pick(req_in.rr_val, req_in.bit_sel); // RULE14
          OP_SKIP_REG_SET: take = bit_pick(req_in.rr_val, req_in.bit_sel);
          OP_SKIP_IO_SET: take = bit_pick(req_in.io_val, req_in.bit_sel); // RULE15
          default: take = ~bit_pick(req_in.io_val, req_in.bit_sel);
        endcase
        // a skipped two-word instruction costs one more cycle
        if (take) begin
          n_cyc = req_in.next_two_word ? `CYC_THREE : `CYC_TWO;
          n_pc = req_in.next_two_word ? pc_reg + PC_W'(3) : pc_reg + PC_W'(2);
        end
      end
      OP_BR_SET, OP_BR_CLR, OP_BR_GE, OP_BR_LT: begin
        unique case (req_in.op)
          OP_BR_SET: take = bit_pick(flags_reg, req_in.bit_sel); // RULE19 RULE20 RULE21
          OP_BR_CLR: take = ~bit_pick(flags_reg, req_in.bit_sel); // RULE19 RULE20 RULE21
          OP_BR_GE: take = ~(flags_reg[`FLG_N] ^ flags_reg[`FLG_V]); // RULE17
          default: take = flags_reg[`FLG_N] ^ flags_reg[`FLG_V]; // RULE18
        endcase
        if (take) begin
          n_cyc = `CYC_TWO; // RULE16
          n_pc = pc_rel(pc_reg, req_in.offset);
        end
      end
      // idle request lines may carry codes outside the operation list
      default: ;
    endcase
  end

  // commit now for single-cycle work, else when the countdown ends
  always_comb begin
    commit = 1'b0;
    c_wb = pend_wb_reg;
    c_flags = pend_flags_reg;
    c_pc = pend_pop_reg ? stack_rdata : pend_pc_reg;
    if (accept && n_cyc == `CYC_ONE) begin
      commit = 1'b1;
      c_wb = n_wb;
      c_flags = n_flags;
      c_pc = n_pc;
    end else if (ce_in && busy_reg && count_reg == 3'h1) begin
      commit = 1'b1;
    end
  end

  // return address stack
  return_stack_mem #(
    .WIDTH(PC_W),
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clk_in(clk_sys_in),
    .ce_in(ce_in),
    .wr_en_in(accept & n_push), // RULE12
    .wr_addr_in(sp_reg),
    .wr_data_in(pc_plus1),
    .rd_en_in(accept & n_pop),
    .rd_addr_in(sp_reg - SP_W'(1)),
    .rd_data_out(stack_rdata)
  );

  // stack pointer; overflow and underflow wrap silently
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sp_reg <= '0;
    end else if (ce_in && accept) begin
      if (n_push) begin
        sp_reg <= sp_reg + SP_W'(1);
      end else if (n_pop) begin
        sp_reg <= sp_reg - SP_W'(1);
      end
    end
  end

  // multi-cycle sequencing: hold results until the last cycle
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      busy_reg <= 1'b0;
      count_reg <= 3'h0;
      pend_wb_reg <= '0;
      pend_flags_reg <= `FLAGS_RST;
      pend_pc_reg <= '0;
      pend_pop_reg <= 1'b0;
    end else if (ce_in) begin
      if (accept && n_cyc != `CYC_ONE) begin
        busy_reg <= 1'b1;
        count_reg <= n_cyc - 3'h1;
        pend_wb_reg <= n_wb;
        pend_flags_reg <= n_flags;
        pend_pc_reg <= n_pc;
        pend_pop_reg <= n_pop;
      end else if (busy_reg) begin
        count_reg <= count_reg - 3'h1;
        busy_reg <= (count_reg != 3'h1);
      end
    end
  end

  // architectural state and result outputs
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pc_reg <= '0;
      wb_reg <= '0;
      done_reg <= 1'b0;
    end else if (ce_in) begin
      done_reg <= commit;
      wb_reg <= commit ? c_wb : '0;
      if (commit) begin
        pc_reg <= c_pc;
      end
    end
  end

  // flags: a finishing instruction beats a software write in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      flags_reg <= `FLAGS_RST;
    end else if (ce_in) begin
      if (commit) begin
        flags_reg <= c_flags;
      end else if (reg_wr_in && reg_addr_in == `ADDR_FLAGS) begin
        flags_reg <= reg_wdata_in;
      end
    end
  end

  // extended high register and read-back port
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ext_high_reg <= `EXT_HIGH_RST;
      rd_data_reg <= 8'h00;
    end else if (ce_in) begin
      if (reg_wr_in && reg_addr_in == `ADDR_EXT_HIGH) begin
        ext_high_reg <= reg_wdata_in[5:0];
      end
      rd_data_reg <= 8'h00;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          `ADDR_FLAGS: rd_data_reg <= flags_reg;
          `ADDR_EXT_HIGH: rd_data_reg <= {2'h0, ext_high_reg};
          `ADDR_PC_LO: rd_data_reg <= pc_reg[7:0];
          `ADDR_PC_MID: rd_data_reg <= pc_reg[15:8];
          `ADDR_PC_HI: rd_data_reg <= 8'(ext_target[21:16] & 6'h00 | 6'(pc_reg >> 16));
          default: rd_data_reg <= 8'h00;
        endcase
      end
    end
  end

  assign busy_out = busy_reg;
  assign done_out = done_reg;
  assign wb_out = wb_reg;
  assign flags_out = flags_reg;
  assign pc_out = pc_reg;
  assign reg_rdata_out = rd_data_reg;

  // checks assume the clock enable stays high
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in || !ce_in);

  sequence s_done_after2;
    !done_reg ##1 done_reg;
  endsequence

  property p_sub_imm_borrow;
    accept && req_in.op == OP_SBC && req_in.use_imm |=> done_reg &&
      wb_reg.data[7:0] == $past(req_in.rd_val) - $past(req_in.imm)
        - {7'h00, $past(flags_reg[`FLG_C])};
  endproperty
  a_sub_imm_borrow: assert property (p_sub_imm_borrow) // RULE1
    else $error("subtract immediate with borrow result wrong");

  property p_word_add;
    accept && req_in.op == OP_WADD |=> s_done_after2 ##0 (wb_reg.word_en &&
      wb_reg.data == $past(req_in.pair_val, 2) + {8'h00, $past(req_in.imm, 2) & 8'h3f});
  endproperty
  a_word_add: assert property (p_word_add) // RULE2
    else $error("word add immediate wrong value or timing");

  property p_word_sub_half;
    accept && req_in.op == OP_WSUB |=> s_done_after2 ##0
      flags_reg[`FLG_H] == $past(flags_reg[`FLG_H], 2);
  endproperty
  a_word_sub_half: assert property (p_word_sub_half) // RULE3
    else $error("word subtract disturbed half carry");

  property p_logic_flags;
    accept && req_in.op inside {OP_AND, OP_OR, OP_EOR} |=> done_reg &&
      !flags_reg[`FLG_V] && flags_reg[`FLG_C] == $past(flags_reg[`FLG_C]);
  endproperty
  a_logic_flags: assert property (p_logic_flags) // RULE4
    else $error("logic operation flags wrong");

  property p_clear_mask;
    accept && req_in.op == OP_CLRMASK && req_in.use_imm |=>
      wb_reg.data[7:0] == ($past(req_in.rd_val) & ~$past(req_in.imm));
  endproperty
  a_clear_mask: assert property (p_clear_mask) // RULE6
    else $error("clear mask bits result wrong");

  property p_mul_unsigned;
    accept && req_in.op == OP_MUL |=> s_done_after2 ##0 (wb_reg.prod_en &&
      wb_reg.data == $past(req_in.rd_val, 2) * $past(req_in.rr_val, 2));
  endproperty
  a_mul_unsigned: assert property (p_mul_unsigned) // RULE8
    else $error("unsigned multiply wrong");

  property p_ind_jump;
    accept && req_in.op == OP_JIND |=> s_done_after2 ##0
      pc_reg == PC_W'($past(req_in.z_ptr, 2));
  endproperty
  a_ind_jump: assert property (p_ind_jump) // RULE10
    else $error("indirect jump target wrong");

  property p_ext_call_len;
    accept && req_in.op == OP_CALLX |=> !done_reg [*3] ##1 done_reg;
  endproperty
  a_ext_call_len: assert property (p_ext_call_len) // RULE12
    else $error("extended indirect call not four cycles");

  property p_cmp_skip;
    accept && req_in.op == OP_SKEQ && req_in.rd_val == req_in.rr_val &&
      !req_in.next_two_word |=> s_done_after2 ##0 pc_reg == $past(pc_reg, 2) + PC_W'(2);
  endproperty
  a_cmp_skip: assert property (p_cmp_skip) // RULE13
    else $error("compare skip equal did not skip");

  property p_branch_ge;
    accept && req_in.op == OP_BR_GE && !(flags_reg[`FLG_N] ^ flags_reg[`FLG_V]) |=>
      s_done_after2 ##0 pc_reg == pc_rel($past(pc_reg, 2), $past(req_in.offset, 2));
  endproperty
  a_branch_ge: assert property (p_branch_ge) // RULE17
    else $error("signed greater-or-equal branch wrong");

  property p_branch_idle;
    accept && req_in.op inside {OP_BR_SET, OP_BR_CLR, OP_BR_GE, OP_BR_LT} && !take |=>
      done_reg && pc_reg == $past(pc_reg) + PC_W'(1);
  endproperty
  a_branch_idle: assert property (p_branch_idle) // RULE16
    else $error("untaken branch not one cycle to next pc");
endmodule

// ### tb/decode_stage_model.sv
`timescale 1ns/10ps
module decode_stage_model import alu_exec_pkg::*; (
  // clock and handshake from the core
  input wire logic clk_in,
  input wire logic busy_in,
  // instruction toward execution
  output logic valid_out,
  output exec_req_t req_out
);
  // idle at start
  initial begin
    valid_out = 1'b0;
    req_out = '0;
  end
  // hold the request until an edge with the core free takes it;
  // a released request shows inverted so nothing can lean on stale operands
  task automatic issue(input exec_req_t r);
    valid_out <= 1'b1;
    req_out <= r;
    do @(posedge clk_in); while (busy_in);
    valid_out <= 1'b0;
    req_out <= ~r;
  endtask
endmodule

// ### tb/tb_alu_branch_exec.sv
`timescale 1ns/10ps
`include "alu_exec_defs.svh"
module tb_alu_branch_exec import alu_exec_pkg::*;;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic busy, done, req_valid;
  exec_req_t req;
  wb_t wb;
  logic [7:0] flags, rdata, v;
  logic [21:0] pc;
  logic [21:0] p = 22'h0;
  int fails = 0;
  int samples_checked = 0;

  // 20 MHz core clock
  always #25 clk_sys_in = ~clk_sys_in;

  alu_branch_exec u_alu_branch_exec (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .ce_in(1'b1), .req_valid_in(req_valid), .req_in(req), .busy_out(busy),
    .done_out(done), .wb_out(wb), .flags_out(flags), .pc_out(pc),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(rdata));

  decode_stage_model u_decode_stage_model (.clk_in(clk_sys_in), .busy_in(busy),
    .valid_out(req_valid), .req_out(req));

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one-cycle register port strobes
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask

  // preset flags, issue one instruction, then check length, write-back, flags, pc
  task automatic go(op_t o, logic u, logic [7:0] a, b, logic [15:0] w, logic [3:0] s,
    logic [11:0] k, logic [7:0] f0, int cyc, logic [2:0] en, logic [15:0] d,
    logic [7:0] f1, logic [21:0] pc1);
    exec_req_t r;
    int n;
    wr(`ADDR_FLAGS, f0);
    r = '{op:o, use_imm:u, rd_val:a, rr_val:(u ? ~b : b), imm:b, pair_val:w, z_ptr:w,
      bit_sel:s[2:0], io_val:a, offset:k, next_two_word:s[3]};
    u_decode_stage_model.issue(r);
    n = 1;
    #1;
    while (done !== 1'b1 && n < 9) begin
      @(posedge clk_sys_in);
      #1 n++;
    end
    chk(n, cyc);
    chk(busy, 1'b0);
    chk({wb.byte_en, wb.word_en, wb.prod_en}, en);
    if (en[2]) chk(wb.data[7:0], d[7:0]);
    else if (en != 3'b000) chk(wb.data, d);
    chk(flags, f1);
    chk(pc, pc1);
    p = pc1;
  endtask

  // watchdog well beyond the expected few hundred cycles
  initial begin
    #(3000 * 50);
    fails++;
    report_and_stop;
  end

  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rd(`ADDR_FLAGS, v);
    chk(v, 8'h00);
    wr(3'h5, 8'hff);
    rd(3'h5, v);
    chk(v, 8'h00);
    go(OP_ADD,0,8'h0f,8'h01,'0,'0,'0,8'h00,1,3'b100,16'h10,8'h20,p+1);
    go(OP_CP,0,8'h05,8'h05,'0,'0,'0,8'h3d,1,3'b000,'0,8'h02,p+1);
    go(OP_SBC,1,8'h00,8'h01,'0,'0,'0,8'h01,1,3'b100,16'hfe,8'h35,p+1);
    go(OP_WADD,1,'0,8'h01,16'hffff,'0,'0,8'h20,2,3'b010,'0,8'h23,p+1);
    go(OP_WSUB,1,'0,8'h01,'0,'0,'0,8'h00,2,3'b010,16'hffff,8'h15,p+1);
    go(OP_EOR,0,8'haa,8'haa,'0,'0,'0,8'h21,1,3'b100,'0,8'h23,p+1);
    go(OP_OR,1,8'h01,8'h80,'0,'0,'0,8'h08,1,3'b100,16'h81,8'h14,p+1);
    go(OP_AND,0,8'hf0,8'h0f,'0,'0,'0,8'h3f,1,3'b100,'0,8'h23,p+1);
    go(OP_SETMASK,1,8'h10,8'h01,'0,'0,'0,8'h0e,1,3'b100,16'h11,8'h00,p+1);
    go(OP_CLRMASK,1,8'hff,8'h0f,'0,'0,'0,8'h00,1,3'b100,16'hf0,8'h14,p+1);
    go(OP_TEST,0,8'h80,'0,'0,'0,'0,8'h02,1,3'b000,'0,8'h14,p+1);
    go(OP_MUL,0,8'hff,8'hff,'0,'0,'0,8'h02,2,3'b001,16'hfe01,8'h01,p+1);
    go(OP_MULS,0,8'h80,8'h80,'0,'0,'0,8'h01,2,3'b001,16'h4000,8'h00,p+1);
    go(OP_MULMX,0,8'hff,8'h02,'0,'0,'0,8'h00,2,3'b001,16'hfffe,8'h01,p+1);
    go(OP_FMUL,0,8'h80,8'h80,'0,'0,'0,8'h03,2,3'b001,16'h8000,8'h00,p+1);
    go(OP_FMULS,0,8'hc0,8'h40,'0,'0,'0,8'h00,2,3'b001,16'he000,8'h01,p+1);
    go(OP_FMULMX,0,'0,8'h05,'0,'0,'0,8'h01,2,3'b001,'0,8'h02,p+1);
    wr(`ADDR_EXT_HIGH, 8'hff);
    rd(`ADDR_EXT_HIGH, v);
    chk(v, 8'h3f);
    go(OP_JXIND,0,'0,'0,16'habcd,'0,'0,8'h00,2,3'b000,'0,8'h00,22'h3fabcd);
    rd(`ADDR_PC_HI, v);
    chk(v, 8'h3f);
    go(OP_JIND,0,'0,'0,16'h1234,'0,'0,8'h00,2,3'b000,'0,8'h00,22'h001234);
    go(OP_CALLX,0,'0,'0,16'h0100,'0,'0,8'h00,4,3'b000,'0,8'h00,22'h3f0100);
    go(OP_RET,0,'0,'0,'0,'0,'0,8'h00,5,3'b000,'0,8'h00,22'h001235);
    go(OP_CALLX,0,'0,'0,16'h0200,'0,'0,8'h00,4,3'b000,'0,8'h00,22'h3f0200);
    go(OP_IRET,0,'0,'0,'0,'0,'0,8'h00,5,3'b000,'0,8'h80,22'h001236);
    go(OP_JREL,0,'0,'0,'0,'0,12'h010,8'h00,2,3'b000,'0,8'h00,p+17);
    go(OP_SKEQ,0,8'h05,8'h05,'0,4'h8,'0,8'h00,3,3'b000,'0,8'h00,p+3);
    go(OP_SKEQ,0,8'h05,8'h05,'0,'0,'0,8'h00,2,3'b000,'0,8'h00,p+2);
    go(OP_SKEQ,0,8'h05,8'h06,'0,'0,'0,8'h00,1,3'b000,'0,8'h00,p+1);
    go(OP_SKIP_REG_CLR,0,'0,8'hf7,'0,4'h3,'0,8'h00,2,3'b000,'0,8'h00,p+2);
    go(OP_SKIP_REG_SET,0,'0,8'hf7,'0,4'h3,'0,8'h00,1,3'b000,'0,8'h00,p+1);
    go(OP_SKIP_IO_SET,0,8'h08,'0,'0,4'h3,'0,8'h00,2,3'b000,'0,8'h00,p+2);
    go(OP_SKIP_IO_CLR,0,8'h08,'0,'0,4'h3,'0,8'h00,1,3'b000,'0,8'h00,p+1);
    go(OP_BR_SET,0,'0,'0,'0,4'h0,12'h004,8'h01,2,3'b000,'0,8'h01,p+5);
    go(OP_BR_CLR,0,'0,'0,'0,4'h0,12'h004,8'h01,1,3'b000,'0,8'h01,p+1);
    go(OP_BR_SET,0,'0,'0,'0,4'h7,12'hffe,8'h80,2,3'b000,'0,8'h80,p-1);
    go(OP_BR_CLR,0,'0,'0,'0,4'h5,12'h004,8'h00,2,3'b000,'0,8'h00,p+5);
    go(OP_BR_GE,0,'0,'0,'0,'0,12'h004,8'h0c,2,3'b000,'0,8'h0c,p+5);
    go(OP_BR_LT,0,'0,'0,'0,'0,12'h004,8'h0c,1,3'b000,'0,8'h0c,p+1);
    go(OP_BR_LT,0,'0,'0,'0,'0,12'h004,8'h04,2,3'b000,'0,8'h04,p+5);
    report_and_stop;
  end
endmodule
